// *** hw/power_monitor_result_regs.v ***
// Result registers, accumulators and output-sample sequencer of a
// current/voltage/power monitor.
// Assumes raw per-conversion samples arrive from the front end on the
// same clock with a one-cycle valid strobe; a register read port is
// driven by the serial interface logic outside this block.
// Selection inputs are levels from the configuration logic; they are
// taken only at a period boundary, so a change shows one period later.
// Accumulator overflow needs at least 65536 periods, far beyond any run.
// Every output is a flip-flop; reads answer one cycle after the strobe.
//
// Notes on behaviour
// - Current 20-bit signed at 7, bus voltage 5
// - Temperature 16, power 24, energy/charge 40 bits
// - Signed results are two's complement
// - Bus voltage code spans up to 204.8 V
// - Each result readable at its own address
// - Energy wraps to zero on overflow
// - Clear bit zeroes accumulators any time
// - Charge overflow sets a sticky flag
// - Eight conversion times, 50 to 4120 us
// - Shortest conversion time is 50 us
// - Averaging counts include 1, 4, 16
// - Output period is conversion time times averages
`timescale 1ns/1ps
`include "pwr_mon_consts.vh"

module power_monitor_result_regs (
    input  wire                       clk_in,              // 125 MHz core clock
    input  wire                       rst_b_in,            // Async reset, active low
    input  wire [2:0]                 conv_sel_in,         // Conversion time select
    input  wire [2:0]                 avg_sel_in,          // Averaging count select
    input  wire                       accumulator_clear_bit_in, // Clear pulse from config
    input  wire                       overflow_clear_in,   // Clears overflow flag
    input  wire                       sample_valid_in,     // Raw sample strobe
    input  wire [`W_CURRENT-1:0]      sample_current_in,   // Raw current, signed
    input  wire [`W_BUS_VOLTAGE-1:0]  sample_voltage_in,   // Raw bus voltage
    input  wire [`W_DIE_TEMP-1:0]     sample_temp_in,      // Raw temperature, signed
    input  wire [`W_POWER-1:0]        sample_power_in,     // Raw power
    input  wire                       read_en_in,          // Register read strobe
    input  wire [3:0]                 read_addr_in,        // Register address
    output reg                        conv_start_out,      // Start of each conversion
    output reg                        result_ready_out,    // New averaged results
    output reg                        charge_overflow_flag_out, // Sticky charge overflow
    output reg  [`W_RDATA-1:0]        read_data_out,       // Read data, zero padded
    output reg                        read_valid_out       // Read data valid
);

    // Conversion length table
    reg  [19:0]  conv_cycles;        // Cycles in one conversion
    reg  [10:0]  avg_count;          // Conversions per output sample
    reg  [3:0]   avg_shift;          // log2 of averaging count

    // Sequencer state
    localparam ST_IDLE = 1'b0;       // Waiting after reset
    localparam ST_RUN  = 1'b1;       // Converting continuously
    reg          state;              // Sequencer state
    reg  [19:0]  conv_timer;         // Cycles left in a conversion
    reg  [10:0]  conv_index;         // Conversions done this period
    reg  [2:0]   conv_sel;           // Selection latched per period
    reg  [2:0]   avg_sel;            // Selection latched per period

    // Averaging sums; wide enough for 1024 samples
    reg  signed [30:0] sum_current;  // Current sum
    reg  [29:0]  sum_voltage;        // Voltage sum
    reg  signed [26:0] sum_temp;     // Temperature sum
    reg  [33:0]  sum_power;          // Power sum

    // Published results
    reg  [`W_CURRENT-1:0]     current_result;
    reg  [`W_BUS_VOLTAGE-1:0] bus_voltage_result;
    reg  [`W_DIE_TEMP-1:0]    die_temperature_result;
    reg  [`W_POWER-1:0]       power_result;
    reg  [`W_ACC-1:0]         energy_accumulator;
    reg  [`W_ACC-1:0]         charge_accumulator;

    wire         period_end;         // Last conversion of the period ends
    wire [`W_ACC:0] next_energy;     // Energy sum with carry
    wire [`W_ACC:0] next_charge;     // Charge sum with carry
    wire [2:0]   load_sel;           // Select for the next timer load

    // Means over the period; the signed shift keeps the sign
    wire signed [30:0] mean_current; // Current mean
    wire [29:0]  mean_voltage;       // Voltage mean
    wire signed [26:0] mean_temp;    // Temperature mean
    wire [33:0]  mean_power;         // Power mean

    // Conversion lengths in whole cycles, sized for the timer
    localparam [19:0] CYC_SEL_0 = `CYC(`TCONV_US_0); // Shortest one
    localparam [19:0] CYC_SEL_1 = `CYC(`TCONV_US_1);
    localparam [19:0] CYC_SEL_2 = `CYC(`TCONV_US_2);
    localparam [19:0] CYC_SEL_3 = `CYC(`TCONV_US_3);
    localparam [19:0] CYC_SEL_4 = `CYC(`TCONV_US_4);
    localparam [19:0] CYC_SEL_5 = `CYC(`TCONV_US_5);
    localparam [19:0] CYC_SEL_6 = `CYC(`TCONV_US_6);
    localparam [19:0] CYC_SEL_7 = `CYC(`TCONV_US_7);

    // Averaging counts, sized for the conversion index
    localparam [10:0] AVG_CNT_0 = `AVG_0;
    localparam [10:0] AVG_CNT_1 = `AVG_1;
    localparam [10:0] AVG_CNT_2 = `AVG_2;
    localparam [10:0] AVG_CNT_3 = `AVG_3;
    localparam [10:0] AVG_CNT_4 = `AVG_4;
    localparam [10:0] AVG_CNT_5 = `AVG_5;
    localparam [10:0] AVG_CNT_6 = `AVG_6;
    localparam [10:0] AVG_CNT_7 = `AVG_7;

    // Conversion time table, counts derived from microseconds;
    // indexed by the select about to be loaded, not the latched one
    always @* begin
        case (load_sel)
            3'h0:    conv_cycles = CYC_SEL_0;
            3'h1:    conv_cycles = CYC_SEL_1;
            3'h2:    conv_cycles = CYC_SEL_2;
            3'h3:    conv_cycles = CYC_SEL_3;
            3'h4:    conv_cycles = CYC_SEL_4;
            3'h5:    conv_cycles = CYC_SEL_5;
            3'h6:    conv_cycles = CYC_SEL_6;
            3'h7:    conv_cycles = CYC_SEL_7;
            default: conv_cycles = CYC_SEL_0;
        endcase
    end

    // Averaging table; powers of two so the mean is a shift.
    // Uses the latched select: the period in flight keeps its count
    always @* begin
        case (avg_sel)
            3'h0:    begin avg_count = AVG_CNT_0; avg_shift = 4'h0; end
            3'h1:    begin avg_count = AVG_CNT_1; avg_shift = 4'h2; end
            3'h2:    begin avg_count = AVG_CNT_2; avg_shift = 4'h4; end
            3'h3:    begin avg_count = AVG_CNT_3; avg_shift = 4'h6; end
            3'h4:    begin avg_count = AVG_CNT_4; avg_shift = 4'h7; end
            3'h5:    begin avg_count = AVG_CNT_5; avg_shift = 4'h8; end
            3'h6:    begin avg_count = AVG_CNT_6; avg_shift = 4'h9; end
            3'h7:    begin avg_count = AVG_CNT_7; avg_shift = 4'hA; end
            default: begin avg_count = AVG_CNT_0; avg_shift = 4'h0; end
        endcase
    end

    // Period ends in the last cycle of its last conversion; the next
    // conversion is loaded at the same edge, so no cycle is lost
    assign period_end = (state == ST_RUN) && (conv_timer == 20'h00000) &&
                        (conv_index == avg_count - 11'h001);

    // A new period loads its length from the fresh select, any
    // other conversion from the select latched for the period
    assign load_sel = (state == ST_IDLE || period_end) ? conv_sel_in : conv_sel;

    // Conversion sequencer; selections change only between periods
    // so one output sample never mixes two settings
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state          <= ST_IDLE;
            conv_timer     <= 20'h00000;
            conv_index     <= 11'h000;
            conv_sel       <= `CONV_SEL_RESET;
            avg_sel        <= `AVG_SEL_RESET;
            conv_start_out <= 1'b0;
        end else begin
            conv_start_out <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // First period after reset: latch and start at once
                    conv_sel       <= conv_sel_in;
                    avg_sel        <= avg_sel_in;
                    conv_timer     <= conv_cycles - 20'h00001;
                    conv_index     <= 11'h000;
                    conv_start_out <= 1'b1;
                    state          <= ST_RUN;
                end
                ST_RUN: begin
                    if (conv_timer == 20'h00000) begin
                        // Conversion done; the next one starts back to back,
                        // which keeps the period an exact multiple
                        conv_timer     <= conv_cycles - 20'h00001;
                        conv_start_out <= 1'b1;
                        if (period_end) begin
                            // Settings for the next period are taken here
                            conv_index <= 11'h000;
                            conv_sel   <= conv_sel_in;
                            avg_sel    <= avg_sel_in;
                        end else begin
                            conv_index <= conv_index + 11'h001;
                        end
                    end else begin
                        // Count down through the conversion
                        conv_timer <= conv_timer - 20'h00001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Running sums over the period, restarted after publication.
    // A sample in the boundary cycle itself is dropped; the front end
    // delivers well inside each conversion, so none is lost there.
    // Sums are sized for 1024 full-scale samples and cannot wrap
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sum_current <= 31'h00000000;
            sum_voltage <= 30'h00000000;
            sum_temp    <= 27'h0000000;
            sum_power   <= 34'h000000000;
        end else if (period_end) begin
            sum_current <= 31'h00000000;
            sum_voltage <= 30'h00000000;
            sum_temp    <= 27'h0000000;
            sum_power   <= 34'h000000000;
        end else if (sample_valid_in && state == ST_RUN) begin
            // Sign extension keeps two's complement sums exact
            sum_current <= sum_current + {{11{sample_current_in[`W_CURRENT-1]}}, sample_current_in};
            sum_voltage <= sum_voltage + {10'h000, sample_voltage_in};
            sum_temp    <= sum_temp + {{11{sample_temp_in[`W_DIE_TEMP-1]}}, sample_temp_in};
            sum_power   <= sum_power + {10'h000, sample_power_in};
        end
    end

    // Means of the sums; the sums restart at the same edge that
    // publishes, so the means are taken from the old sums here
    assign mean_current = sum_current >>> avg_shift;
    assign mean_voltage = sum_voltage >> avg_shift;
    assign mean_temp    = sum_temp >>> avg_shift;
    assign mean_power   = sum_power >> avg_shift;

    // Publish averaged results only at period end
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            current_result         <= 20'h00000;
            bus_voltage_result     <= 20'h00000;
            die_temperature_result <= 16'h0000;
            power_result           <= 24'h000000;
            result_ready_out       <= 1'b0;
        end else begin
            result_ready_out <= period_end;
            if (period_end) begin
                // Low bits of each mean; identical samples give back
                // the sample itself, the upper bits are only sign
                current_result         <= mean_current[`W_CURRENT-1:0];
                // Full 20-bit code kept unsigned, covering 204.8 V
                bus_voltage_result     <= mean_voltage[`W_BUS_VOLTAGE-1:0];
                die_temperature_result <= mean_temp[`W_DIE_TEMP-1:0];
                power_result           <= mean_power[`W_POWER-1:0];
            end
        end
    end

    // Energy and charge grow each published sample
    assign next_energy = {1'b0, energy_accumulator} + {17'h00000, power_result};
    assign next_charge = {1'b0, charge_accumulator} +
                         {21'h000000, (current_result[`W_CURRENT-1] ? -current_result : current_result)};

    // Accumulators; clear has priority at any time and also holds
    // off the accumulation, so no overflow is raised while clearing.
    // The flag set wins over its own clear in one cycle, so an
    // overflow is never lost to a badly timed clear
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            energy_accumulator       <= 40'h0000000000;
            charge_accumulator       <= 40'h0000000000;
            charge_overflow_flag_out <= 1'b0;
        end else begin
            if (accumulator_clear_bit_in) begin
                energy_accumulator <= 40'h0000000000;
                charge_accumulator <= 40'h0000000000;
            end else if (result_ready_out) begin
                // Carry dropped so energy rolls over from zero
                energy_accumulator <= next_energy[`W_ACC-1:0];
                // Charge wraps too and keeps accumulating from the wrapped value until the host clears it
                charge_accumulator <= next_charge[`W_ACC-1:0];
            end
            if (result_ready_out && !accumulator_clear_bit_in && next_charge[`W_ACC])
                charge_overflow_flag_out <= 1'b1;
            else if (overflow_clear_in)
                charge_overflow_flag_out <= 1'b0;
        end
    end

    // Register read port, one cycle latency, zero on other addresses.
    // One 40-bit word carries every result; narrower ones are zero
    // padded so the host never sees stray upper bits
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            read_data_out  <= 40'h0000000000;
            read_valid_out <= 1'b0;
        end else begin
            read_valid_out <= read_en_in;
            if (read_en_in) begin
                case (read_addr_in)
                    `ADDR_BUS_VOLTAGE: read_data_out <= {20'h00000, bus_voltage_result};
                    `ADDR_DIE_TEMP:    read_data_out <= {24'h000000, die_temperature_result};
                    `ADDR_CURRENT:     read_data_out <= {20'h00000, current_result};
                    `ADDR_POWER:       read_data_out <= {16'h0000, power_result};
                    `ADDR_ENERGY:      read_data_out <= energy_accumulator;
                    `ADDR_CHARGE:      read_data_out <= charge_accumulator;
                    default:           read_data_out <= 40'h0000000000;
                endcase
            end
        end
    end

endmodule // power_monitor_result_regs

// *** hw/pwr_mon_consts.vh ***
// Constants for the power monitor result block: register addresses,
// field widths, conversion-time and averaging tables.
// Assumes a 125 MHz core clock (8 ns period).
`ifndef PWR_MON_CONSTS_VH
`define PWR_MON_CONSTS_VH

// Result register addresses
`define ADDR_BUS_VOLTAGE    4'h5
`define ADDR_DIE_TEMP       4'h6
`define ADDR_CURRENT        4'h7
`define ADDR_POWER          4'h8
`define ADDR_ENERGY         4'h9
`define ADDR_CHARGE         4'hA

// Result widths
`define W_CURRENT           20
`define W_BUS_VOLTAGE       20
`define W_DIE_TEMP          16
`define W_POWER             24
`define W_ACC               40
`define W_RDATA             40

// Core clock rate in kHz, and conversion times in microseconds
`define CLK_KHZ             125000
`define TCONV_US_0          50
`define TCONV_US_1          84
`define TCONV_US_2          150
`define TCONV_US_3          280
`define TCONV_US_4          540
`define TCONV_US_5          1052
`define TCONV_US_6          2074
`define TCONV_US_7          4120
// Cycles per conversion: time times rate (exact, whole cycles)
`define CYC(us)             ((us) * `CLK_KHZ / 1000)

// Averaging counts selectable by a 3-bit code
`define AVG_0               1
`define AVG_1               4
`define AVG_2               16
`define AVG_3               64
`define AVG_4               128
`define AVG_5               256
`define AVG_6               512
`define AVG_7               1024

// Reset values of the selection fields
`define CONV_SEL_RESET      3'h0
`define AVG_SEL_RESET       3'h0

`endif

// *** test/pmr_chk.sv ***
// Checker for the power monitor result block, bound to its top module.
// Assumes one 125 MHz clock and the async active-low reset.
`timescale 1ns/1ps
module pmr_chk (
    input logic        clk_in,                   // Core clock
    input logic        rst_b_in,                 // Reset, active low
    input logic        accumulator_clear_bit_in, // Accumulator clear
    input logic        overflow_clear_in,        // Overflow flag clear
    input logic        read_en_in,               // Read strobe
    input logic [3:0]  read_addr_in,             // Read address
    input logic        result_ready_out,         // Results published
    input logic        charge_overflow_flag_out, // Sticky overflow
    input logic [39:0] read_data_out,            // Read data
    input logic        read_valid_out            // Read data valid
);
    // One domain, so one default clock and disable
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_rd_lat; read_en_in |=> read_valid_out; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
    property p_rd_only; read_valid_out |-> $past(read_en_in); endproperty
    a_rd_only: assert property (p_rd_only) else $error("read answer without request");
    property p_unmapped; read_en_in && (read_addr_in < 4'h5 || read_addr_in > 4'hA) |=> read_data_out == 40'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cur_w; read_en_in && read_addr_in == 4'h7 |=> read_data_out[39:20] == 20'h0; endproperty
    a_cur_w: assert property (p_cur_w) else $error("current wider than 20 bits");
    property p_tmp_w; read_en_in && read_addr_in == 4'h6 |=> read_data_out[39:16] == 24'h0; endproperty
    a_tmp_w: assert property (p_tmp_w) else $error("temperature wider than 16 bits");
    property p_pwr_w; read_en_in && read_addr_in == 4'h8 |=> read_data_out[39:24] == 16'h0; endproperty
    a_pwr_w: assert property (p_pwr_w) else $error("power wider than 24 bits");
    // Clear must win even a read right behind it
    property p_clr; (accumulator_clear_bit_in && !result_ready_out) ##1 (read_en_in && read_addr_in == 4'h9)
        |=> read_data_out == 40'h0; endproperty
    a_clr: assert property (p_clr) else $error("energy not zero after clear");
    property p_of_hold; charge_overflow_flag_out && !overflow_clear_in |=> charge_overflow_flag_out; endproperty
    a_of_hold: assert property (p_of_hold) else $error("overflow flag dropped");
    // Shortest period is thousands of cycles, so eight quiet ones is safe
    property p_rdy_gap; result_ready_out |=> !result_ready_out [*8]; endproperty
    a_rdy_gap: assert property (p_rdy_gap) else $error("results published too often");
endmodule // pmr_chk
bind power_monitor_result_regs pmr_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .accumulator_clear_bit_in(accumulator_clear_bit_in), .overflow_clear_in(overflow_clear_in),
    .read_en_in(read_en_in), .read_addr_in(read_addr_in), .result_ready_out(result_ready_out),
    .charge_overflow_flag_out(charge_overflow_flag_out), .read_data_out(read_data_out),
    .read_valid_out(read_valid_out));

// *** test/sample_feeder.sv ***
// Front-end stand-in: one raw sample per conversion start.
// Assumes the block's clock; values come from the bench.
`timescale 1ns/1ps
module sample_feeder (
    input  wire        clk_in,        // Core clock
    input  wire        conv_start_in, // Conversion start pulse
    input  wire [19:0] cur_in,        // Current to deliver
    input  wire [19:0] vol_in,        // Bus voltage to deliver
    input  wire [15:0] tmp_in,        // Temperature to deliver
    input  wire [23:0] pwr_in,        // Power to deliver
    output reg         valid_out = 1'b0, // Sample strobe
    output reg  [19:0] cur_out = 20'h0,  // Sample current
    output reg  [19:0] vol_out = 20'h0,  // Sample voltage
    output reg  [15:0] tmp_out = 16'h0,  // Sample temperature
    output reg  [23:0] pwr_out = 24'h0   // Sample power
);
    integer wait_cnt = 0; // Cycles left before the sample lands
    // Sample lands well inside the conversion, data inverted otherwise
    always @(posedge clk_in) begin
        wait_cnt <= conv_start_in ? 100 : (wait_cnt > 0 ? wait_cnt - 1 : 0);
        valid_out <= (wait_cnt == 1);
        cur_out <= (wait_cnt == 1) ? cur_in : ~cur_in;
        vol_out <= (wait_cnt == 1) ? vol_in : ~vol_in;
        tmp_out <= (wait_cnt == 1) ? tmp_in : ~tmp_in;
        pwr_out <= (wait_cnt == 1) ? pwr_in : ~pwr_in;
    end
endmodule // sample_feeder

// *** test/testbench.sv ***
// Self-checking bench for the result block with a sample feeder.
// Assumes 125 MHz clock; full-length conversion counts are used.
`timescale 1ns/1ps
module testbench;
    reg         clk_in = 1'b0;     // Core clock
    reg         rst_b_in = 1'b0;   // Reset, active low
    reg  [2:0]  avg_sel = 3'h0;    // Averaging select
    reg  [2:0]  conv_sel = 3'h0;   // Conversion time select
    reg         acc_clr = 1'b0;    // Accumulator clear
    reg         of_clr = 1'b0;     // Overflow flag clear
    reg         rd_en = 1'b0;      // Read strobe
    reg  [3:0]  rd_addr = 4'h0;    // Read address
    reg  [19:0] cur_v = 20'hFFFFD; // Minus three current steps
    wire        s_valid, c_start, r_ready, of_flag, rd_valid;
    wire [19:0] s_cur, s_vol;
    wire [15:0] s_tmp;
    wire [23:0] s_pwr;
    wire [39:0] rd_data;
    integer     n_fail = 0, n_compared = 0, cycles = 0, starts = 0, s2, t1, t2, t3, t4, t5;
    localparam [19:0] VOL = 20'h32000; // 40 V at 195.3125 uV a step
    localparam [15:0] TMP = 16'hF380;  // Below zero
    localparam [23:0] PWR = 24'h123456;
    initial forever #4 clk_in = ~clk_in;
    sample_feeder feeder (.clk_in(clk_in), .conv_start_in(c_start), .cur_in(cur_v), .vol_in(VOL),
        .tmp_in(TMP), .pwr_in(PWR), .valid_out(s_valid), .cur_out(s_cur), .vol_out(s_vol),
        .tmp_out(s_tmp), .pwr_out(s_pwr));
    power_monitor_result_regs uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .conv_sel_in(conv_sel),
        .avg_sel_in(avg_sel), .accumulator_clear_bit_in(acc_clr), .overflow_clear_in(of_clr),
        .sample_valid_in(s_valid), .sample_current_in(s_cur), .sample_voltage_in(s_vol),
        .sample_temp_in(s_tmp), .sample_power_in(s_pwr), .read_en_in(rd_en), .read_addr_in(rd_addr),
        .conv_start_out(c_start), .result_ready_out(r_ready), .charge_overflow_flag_out(of_flag),
        .read_data_out(rd_data), .read_valid_out(rd_valid));
    // Compare and count
    task check(input [39:0] seen, input [39:0] want);
        begin
            n_compared = n_compared + 1;
            if (seen !== want) begin
                n_fail = n_fail + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
            end
        end
    endtask
    // One register read, answer one cycle later
    task rd(input [3:0] a, input [39:0] want);
        begin
            rd_en = 1'b1;
            rd_addr = a;
            @(posedge clk_in); #1;
            // Valid stands for just this one cycle
            check({39'h0, rd_valid}, 40'h1);
            check(rd_data, want);
            rd_en = 1'b0;
            @(posedge clk_in); #1;
        end
    endtask
    // Bounded wait for published results, returns the cycle stamp
    task wait_ready(output integer t);
        integer n;
        begin
            n = 0;
            while (r_ready !== 1'b1 && n < 30000) begin
                @(posedge clk_in); #1;
                n = n + 1;
            end
            check({39'h0, r_ready}, 40'h1);
            t = cycles;
            @(posedge clk_in); #1; // Let the accumulator update land
        end
    endtask
    task end_sim;
        begin
            if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // Cycle stamp, conversion count and hang guard; run is about 67k cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (c_start === 1'b1)
            starts <= starts + 1;
        if (cycles == 80000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        rd(4'h0, 40'h0);
        wait_ready(t1);
        rd(4'h7, {20'h0, 20'hFFFFD});
        rd(4'h5, {20'h0, VOL});
        rd(4'h6, {24'h0, TMP});
        rd(4'h8, {16'h0, PWR});
        rd(4'h9, {16'h0, PWR});
        rd(4'hA, 40'h3);
        rd(4'hB, 40'h0);
        avg_sel = 3'h1;                  // Taken at the next period start
        wait_ready(t2);
        s2 = starts;
        check(t2 - t1, 6250);
        rd(4'h9, {15'h0, PWR, 1'b0});
        cur_v = 20'hFFFF0;
        repeat (300) @(posedge clk_in); #1;
        rd(4'h7, {20'h0, 20'hFFFFD});
        avg_sel = 3'h0;                  // Both taken at the next period start
        conv_sel = 3'h1;
        wait_ready(t3);
        check(t3 - t2, 25000);
        check(starts - s2, 4);
        rd(4'h7, {20'h0, 20'hFFFF0});
        rd(4'hA, 40'h16);
        acc_clr = 1'b1;
        @(posedge clk_in); #1;
        acc_clr = 1'b0;
        rd(4'h9, 40'h0);
        rd(4'hA, 40'h0);
        of_clr = 1'b1;
        @(posedge clk_in); #1;
        of_clr = 1'b0;
        check({39'h0, of_flag}, 40'h0);
        conv_sel = 3'h2;                 // Taken at the next period start
        wait_ready(t4);
        check(t4 - t3, 10500);
        rd(4'h9, {16'h0, PWR});
        wait_ready(t5);
        check(t5 - t4, 18750);
        end_sim;
    end
endmodule // testbench
